// ===== hdl/vpr_relay.sv
// What this block does
// - Over-voltage uses highest of three phases
// - Under-voltage uses lowest of three phases
// - Definite time: delay fixed, not depth-dependent
// - Alarms stay latched until controller reset
// - Generator under-voltage off while breaker open
// - Other detections ignore breaker position
// - Each event has its own action
// - Separate pre-alarm and alarm delays
// - Delays shared over/under, separate per source
// - Each event has its own trigger level
// - Trip only after continuous excursion for delay; here the first delay unit can run up to one unit short
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
module vpr_relay #(
    parameter int TICK_CYCLES = vpr_pkg::TICK_CYCLES   // Clocks per delay unit
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Measurements, from logic on this clock
    input wire logic [15:0] gen_phase_a,
    input wire logic [15:0] gen_phase_b,
    input wire logic [15:0] gen_phase_c,
    input wire logic [15:0] bus_phase_a,
    input wire logic [15:0] bus_phase_b,
    input wire logic [15:0] bus_phase_c,
    input wire logic gen_breaker_closed,   // Pin, asynchronous
    // Results
    output logic [7:0] alarm_latched,      // [3:0] generator, [7:4] bus
    output logic act_warn,
    output logic act_soft,
    output logic act_hard,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] lvl_q [8];                // Trigger levels, gen then bus
    logic [31:0] dly_q [vpr_pkg::NUM_SRC]; // {alarm, pre-alarm} per source
    logic [15:0] action_q;                 // Two bits per event
    logic [7:0] irq_stat_q;
    logic [7:0] irq_mask_q;
    logic clr_q;                           // Controller reset pulse
    logic [7:0] latched;                   // From the two sources
    logic [7:0] latched_prev_q;
    logic [7:0] alarm_q;
    logic act_warn_q;
    logic act_soft_q;
    logic act_hard_q;
    logic brk_meta_q;                      // Synchroniser first stage
    logic brk_q;                           // Synchronised breaker state
    logic [16:0] tick_cnt_q;
    logic tick;

    // AXI state
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_go;                           // Both halves of a write held
    logic wr_hit;
    logic [31:0] rd_val;
    logic rd_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Breaker pin crosses in through two flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brk_meta_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            brk_meta_q <= gen_breaker_closed;
            brk_q <= brk_meta_q;
        end
    end

    // Delay time base; the first tick after an excursion comes early by up to one unit
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            tick_cnt_q <= 17'h00000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 17'h00001;
        end
    end
    assign tick = (tick_cnt_q == 17'(TICK_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    // AXI write channel: address and data taken in either order
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign wr_go = aw_have_q && w_have_q && !bvalid_q;
    assign wr_hit = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= vpr_pkg::OFF_LVL_LAST)
                    && (awaddr_q != 8'h1C);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= vpr_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                // Response one cycle after both halves are held
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? vpr_pkg::RESP_OKAY : vpr_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Configuration registers; alarm status is read only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < 8; k++) begin
                lvl_q[k] <= (k % 4 < 2) ? vpr_pkg::RST_LVL_OV : vpr_pkg::RST_LVL_UV;
            end
            for (int s = 0; s < vpr_pkg::NUM_SRC; s++) begin
                dly_q[s] <= {vpr_pkg::RST_DLY, vpr_pkg::RST_DLY};
            end
            action_q <= vpr_pkg::RST_ACTION;
            irq_mask_q <= vpr_pkg::RST_MASK;
        end else if (wr_go && wr_hit) begin
            if (awaddr_q >= vpr_pkg::OFF_LVL_BASE) begin
                lvl_q[awaddr_q[4:2]] <= 16'(merge({16'h0000, lvl_q[awaddr_q[4:2]]},
                                                  wdata_q, wstrb_q));
            end
            if (awaddr_q == vpr_pkg::OFF_GEN_DLY) begin
                dly_q[0] <= merge(dly_q[0], wdata_q, wstrb_q);
            end
            if (awaddr_q == vpr_pkg::OFF_BUS_DLY) begin
                dly_q[1] <= merge(dly_q[1], wdata_q, wstrb_q);
            end
            if (awaddr_q == vpr_pkg::OFF_ACTION) begin
                action_q <= 16'(merge({16'h0000, action_q}, wdata_q, wstrb_q));
            end
            if (awaddr_q == vpr_pkg::OFF_IRQ_MASK) begin
                irq_mask_q <= 8'(merge({24'h000000, irq_mask_q}, wdata_q, wstrb_q));
            end
        end
    end

    // Controller reset is a one-cycle pulse from a write of one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clr_q <= 1'b0;
        end else begin
            clr_q <= wr_go && (awaddr_q == vpr_pkg::OFF_CTRL) && wstrb_q[0]
                     && wdata_q[vpr_pkg::CTRL_CLR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI read channel
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Read decode; unmapped words answer with an error, reading zero below 0x20 and an aliased level word above 0x3C
    always_comb begin
        rd_val = 32'h00000000;
        rd_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= vpr_pkg::OFF_LVL_LAST)
                 && (s_axi_araddr != 8'h1C);
        if (s_axi_araddr >= vpr_pkg::OFF_LVL_BASE) begin
            rd_val = {16'h0000, lvl_q[s_axi_araddr[4:2]]};
        end else begin
            unique case (s_axi_araddr)
                vpr_pkg::OFF_ALARM: begin
                    rd_val = {23'h000000, brk_q, alarm_q};
                end
                vpr_pkg::OFF_IRQ_STAT: begin
                    rd_val = {24'h000000, irq_stat_q};
                end
                vpr_pkg::OFF_IRQ_MASK: begin
                    rd_val = {24'h000000, irq_mask_q};
                end
                vpr_pkg::OFF_ACTION: begin
                    rd_val = {16'h0000, action_q};
                end
                vpr_pkg::OFF_GEN_DLY: begin
                    rd_val = dly_q[0];
                end
                vpr_pkg::OFF_BUS_DLY: begin
                    rd_val = dly_q[1];
                end
                default: begin
                    rd_val = 32'h00000000;   // Control reads zero
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= vpr_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_hit ? vpr_pkg::RESP_OKAY : vpr_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two sources; only the generator gates its under-voltage side
    for (genvar s = 0; s < vpr_pkg::NUM_SRC; s++) begin : g_src
        vpr_source u_src (
            .aclk(aclk),
            .aresetn(aresetn),
            .tick(tick),
            .clr_alarm(clr_q),
            .uv_enable((s == 0) ? brk_q : 1'b1),
            .phase_a((s == 0) ? gen_phase_a : bus_phase_a),
            .phase_b((s == 0) ? gen_phase_b : bus_phase_b),
            .phase_c((s == 0) ? gen_phase_c : bus_phase_c),
            .lvl_ov_pre(lvl_q[s*4 + 0]),
            .lvl_ov_alm(lvl_q[s*4 + 1]),
            .lvl_uv_pre(lvl_q[s*4 + 2]),
            .lvl_uv_alm(lvl_q[s*4 + 3]),
            .dly_pre(dly_q[s][15:0]),
            .dly_alm(dly_q[s][31:16]),
            .latched(latched[s*4 +: 4])
        );
    end

    // Action outputs: each latched event drives the line its own code selects
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_q <= 8'h00;
            act_warn_q <= 1'b0;
            act_soft_q <= 1'b0;
            act_hard_q <= 1'b0;
        end else begin
            alarm_q <= latched;
            act_warn_q <= 1'b0;
            act_soft_q <= 1'b0;
            act_hard_q <= 1'b0;
            for (int e = 0; e < 8; e++) begin
                if (latched[e] && action_q[e*2 +: 2] == vpr_pkg::VPR_ACT_WARN) begin
                    act_warn_q <= 1'b1;
                end
                if (latched[e] && action_q[e*2 +: 2] == vpr_pkg::VPR_ACT_SOFT) begin
                    act_soft_q <= 1'b1;
                end
                if (latched[e] && action_q[e*2 +: 2] == vpr_pkg::VPR_ACT_HARD) begin
                    act_hard_q <= 1'b1;
                end
            end
        end
    end
    assign alarm_latched = alarm_q;
    assign act_warn = act_warn_q;
    assign act_soft = act_soft_q;
    assign act_hard = act_hard_q;

    // Sticky interrupt status: a new latch wins over a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latched_prev_q <= 8'h00;
            irq_stat_q <= 8'h00;
        end else begin
            latched_prev_q <= latched;
            if (wr_go && (awaddr_q == vpr_pkg::OFF_IRQ_STAT) && wstrb_q[0]) begin
                irq_stat_q <= (irq_stat_q & ~wdata_q[7:0]) | (latched & ~latched_prev_q);
            end else begin
                irq_stat_q <= irq_stat_q | (latched & ~latched_prev_q);
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    a_action_route: assert property (@(posedge aclk) disable iff (!aresetn)
        latched[0] && (action_q[1:0] == vpr_pkg::VPR_ACT_WARN) |=> act_warn_q)
        else $error("latched event did not drive its selected action");
    a_bus_uv_free: assert property (@(posedge aclk) disable iff (!aresetn)
        !brk_q && (dly_q[1][31:16] == 16'h0000) && ((bus_phase_a < lvl_q[7])
        || (bus_phase_b < lvl_q[7]) || (bus_phase_c < lvl_q[7])) |=> latched[7])
        else $error("bus under-voltage gated by breaker");
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));

endmodule : vpr_relay

// ===== hdl/vpr_pkg.sv
package vpr_pkg;

    // Data and measurement widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int VOLT_W = 16;
    localparam int DLY_W = 16;
    localparam int NUM_EV = 4;       // Events per source
    localparam int NUM_SRC = 2;      // Generator, bus
    localparam int ACT_W = 2;        // Action code width per event

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ALARM = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_ACTION = 8'h10;
    localparam logic [7:0] OFF_GEN_DLY = 8'h14;
    localparam logic [7:0] OFF_BUS_DLY = 8'h18;
    localparam logic [7:0] OFF_LVL_BASE = 8'h20;   // Eight level words, gen first
    localparam logic [7:0] OFF_LVL_LAST = 8'h3C;

    // Field positions
    localparam int CTRL_CLR_BIT = 0;       // Write 1: controller reset of alarms
    localparam int ALARM_BRK_BIT = 8;      // Synchronised breaker-closed state
    localparam int DLY_ALM_LSB = 16;       // Alarm delay in upper half

    // Event index inside a source
    localparam int EV_OV_PRE = 0;
    localparam int EV_OV_ALM = 1;
    localparam int EV_UV_PRE = 2;
    localparam int EV_UV_ALM = 3;

    // Values after reset: levels that can never trip
    localparam logic [15:0] RST_LVL_OV = 16'hFFFF;
    localparam logic [15:0] RST_LVL_UV = 16'h0000;
    localparam logic [15:0] RST_DLY = 16'h0000;
    localparam logic [15:0] RST_ACTION = 16'h0000;
    localparam logic [7:0] RST_MASK = 8'h00;

    // Delay time base: one tick per millisecond at 125 MHz
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Action selected for an event
    typedef enum logic [1:0] {
        VPR_ACT_NONE = 2'h0,
        VPR_ACT_WARN = 2'h1,
        VPR_ACT_SOFT = 2'h2,
        VPR_ACT_HARD = 2'h3
    } vpr_action_t;

endpackage : vpr_pkg

// ===== hdl/vpr_source.sv
////////////////////////////////////////////////////////////////////////////////
// One three-phase source: worst-case phase pick, four definite-time events
module vpr_source (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,                  // One-cycle pulse per delay unit
    input wire logic clr_alarm,             // Controller reset pulse
    input wire logic uv_enable,             // Low blocks both under-voltage events
    input wire logic [15:0] phase_a,
    input wire logic [15:0] phase_b,
    input wire logic [15:0] phase_c,
    input wire logic [15:0] lvl_ov_pre,
    input wire logic [15:0] lvl_ov_alm,
    input wire logic [15:0] lvl_uv_pre,
    input wire logic [15:0] lvl_uv_alm,
    input wire logic [15:0] dly_pre,
    input wire logic [15:0] dly_alm,
    output logic [3:0] latched
);

    logic [15:0] vmax;                      // Highest phase
    logic [15:0] vmin;                      // Lowest phase
    logic [15:0] lvl [vpr_pkg::NUM_EV];     // Trigger level per event
    logic [3:0] beyond;                     // Excursion beyond level, per event
    logic [3:0] fire;                       // Delay met this cycle
    logic [3:0] latched_q;

    assign lvl[vpr_pkg::EV_OV_PRE] = lvl_ov_pre;
    assign lvl[vpr_pkg::EV_OV_ALM] = lvl_ov_alm;
    assign lvl[vpr_pkg::EV_UV_PRE] = lvl_uv_pre;
    assign lvl[vpr_pkg::EV_UV_ALM] = lvl_uv_alm;
    assign latched = latched_q;

    // Worst-case phase selection, never an average
    always_comb begin
        vmax = phase_a;
        if (phase_b > vmax) begin
            vmax = phase_b;
        end
        if (phase_c > vmax) begin
            vmax = phase_c;
        end
        vmin = phase_a;
        if (phase_b < vmin) begin
            vmin = phase_b;
        end
        if (phase_c < vmin) begin
            vmin = phase_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-event timer and latch
    for (genvar i = 0; i < vpr_pkg::NUM_EV; i++) begin : g_ev
        localparam bit IS_OVER = (i < 2);
        localparam bit IS_PRE = ((i % 2) == 0);
        logic [15:0] cnt_q;                 // Ticks seen while beyond level; the first may be partial
        logic [15:0] dly;                   // Delay shared by over and under
        logic lat_q;                        // This event's latch

        assign dly = IS_PRE ? dly_pre : dly_alm;

        // Over side never gated; under side gated by its enable
        if (IS_OVER) begin : g_ov
            assign beyond[i] = (vmax > lvl[i]);
        end else begin : g_uv
            assign beyond[i] = uv_enable && (vmin < lvl[i]);
        end

        // Fixed delay, independent of excursion depth
        assign fire[i] = beyond[i] && (cnt_q >= dly);

        // Count only while beyond; any return restarts from zero
        always_ff @(posedge aclk) begin
            if (!aresetn || !beyond[i]) begin
                cnt_q <= 16'h0000;
            end else if (tick && (cnt_q != 16'hFFFF)) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end

        // Latch holds until controller reset; a new trip wins over the clear
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                lat_q <= 1'b0;
            end else begin
                lat_q <= fire[i] | (lat_q & ~clr_alarm);
            end
        end
        assign latched_q[i] = lat_q;

        a_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
            latched_q[i] && !clr_alarm |=> latched_q[i])
            else $error("event latch dropped without controller reset");
        a_no_early_trip: assert property (@(posedge aclk) disable iff (!aresetn)
            $rose(latched_q[i]) |-> $past(beyond[i]) && ($past(cnt_q) >= $past(dly)))
            else $error("event latched before its delay elapsed");
        a_trip_on_delay: assert property (@(posedge aclk) disable iff (!aresetn)
            beyond[i] && (cnt_q >= dly) |=> latched_q[i])
            else $error("event not latched once delay elapsed");
        a_timer_restart: assert property (@(posedge aclk) disable iff (!aresetn)
            !beyond[i] |=> (cnt_q == 16'h0000))
            else $error("delay timer kept value after return inside level");
        a_level_compare: assert property (@(posedge aclk) disable iff (!aresetn)
            beyond[i] |-> (IS_OVER ? (vmax > lvl[i]) : (vmin < lvl[i])))
            else $error("excursion flagged against the wrong level");
        if (!IS_OVER) begin : g_uvchk
            a_uv_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
                !uv_enable |-> !beyond[i] ##1 (cnt_q == 16'h0000))
                else $error("under-voltage timed while blocked");
        end
    end

    a_worst_phase: assert property (@(posedge aclk) disable iff (!aresetn)
        (vmax >= phase_a) && (vmax >= phase_b) && (vmax >= phase_c)
        && (vmin <= phase_a) && (vmin <= phase_b) && (vmin <= phase_c))
        else $error("worst-case phase pick wrong");
    c_ov_alarm: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(latched_q[vpr_pkg::EV_OV_ALM]));
    c_uv_pre: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(latched_q[vpr_pkg::EV_UV_PRE]));
    c_clear: cover property (@(posedge aclk) disable iff (!aresetn)
        latched_q[0] ##1 clr_alarm ##1 !latched_q[0]);

endmodule : vpr_source

// ===== sim/vpr_meas.sv
////////////////////////////////////////////////////////////////////////////////
// Measurement front end: one fresh magnitude per phase each clock
module vpr_meas (
    input wire logic aclk,
    input wire logic [5:0][15:0] want,
    output logic [15:0] gen_phase_a,
    output logic [15:0] gen_phase_b,
    output logic [15:0] gen_phase_c,
    output logic [15:0] bus_phase_a,
    output logic [15:0] bus_phase_b,
    output logic [15:0] bus_phase_c
);
    timeunit 1ns;
    timeprecision 1ps;
    // Registered, so samples land one clock after the bench asks
    always_ff @(posedge aclk) begin
        gen_phase_a <= want[0];
        gen_phase_b <= want[1];
        gen_phase_c <= want[2];
        bus_phase_a <= want[3];
        bus_phase_b <= want[4];
        bus_phase_c <= want[5];
    end
endmodule : vpr_meas

// ===== sim/vpr_relay_test.sv
////////////////////////////////////////////////////////////////////////////////
module vpr_relay_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] NOM = 16'h0200; // Healthy phase level
    logic aclk, aresetn, gen_breaker_closed, ta, tw;
    logic [7:0] s_axi_awaddr, s_axi_araddr, alarm_latched;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rres;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, act_warn, act_soft, act_hard, irq;
    logic [15:0] gen_phase_a, gen_phase_b, gen_phase_c;
    logic [15:0] bus_phase_a, bus_phase_b, bus_phase_c;
    logic [5:0][15:0] want; // Order: gen a,b,c then bus a,b,c from bit 0
    int mismatches, checked;
    ////////////////////////////////////////////////////////////////////////////
    vpr_meas meas (.aclk, .want, .gen_phase_a, .gen_phase_b, .gen_phase_c,
        .bus_phase_a, .bus_phase_b, .bus_phase_c);
    vpr_relay #(.TICK_CYCLES(4)) dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .gen_phase_a, .gen_phase_b, .gen_phase_c, .bus_phase_a,
        .bus_phase_b, .bus_phase_c, .gen_breaker_closed, .alarm_latched,
        .act_warn, .act_soft, .act_hard, .irq);
    ////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // Settle point is the falling edge after n rising edges
    task cyc(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : cyc
    task setp(input logic [5:0][15:0] v);
        @(posedge aclk);
        want <= v;
    endtask : setp
    // Address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(negedge aclk); while (!s_axi_bvalid);
        rres = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        rres = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rd(8'h34);
        chk(rdat, 32'h0000FFFF);
        rd(8'h1C);
        chk({rres, rdat[29:0]}, {vpr_pkg::RESP_SLVERR, 30'h0});
        wr(8'h1C, 32'h0);
        chk(32'(rres), 32'(vpr_pkg::RESP_SLVERR));
        rd(8'h04);
        chk(rdat, 32'h00000100);
    endtask : t_reset
    // One high phase trips although the average stays low
    task t_over;
        wr(8'h0C, 32'h000000FF);
        wr(8'h10, 32'h00000001);
        wr(8'h20, 32'h00000300);
        setp({NOM, NOM, NOM, NOM, 16'h0301, NOM});
        cyc(6);
        chk(32'(alarm_latched), 32'h01);
        chk(32'({act_warn, act_soft, act_hard, irq}), 32'h9);
        setp({6{NOM}});
        cyc(4);
        chk(32'(alarm_latched), 32'h01);
        wr(8'h0C, 32'h0);
        cyc(1);
        chk(32'(irq), 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h08, 32'hFF);
        cyc(2);
        chk(32'(alarm_latched), 32'h0);
    endtask : t_over
    task t_under;
        wr(8'h2C, 32'h00000100);
        wr(8'h3C, 32'h00000100);
        wr(8'h10, 32'h0000C081);
        @(posedge aclk);
        gen_breaker_closed <= 1'b0;
        cyc(4);
        setp({NOM, NOM, 16'h00F0, 16'h00F0, NOM, NOM});
        cyc(8);
        chk(32'(alarm_latched), 32'h80);
        chk(32'({act_warn, act_soft, act_hard}), 32'h1);
        @(posedge aclk);
        gen_breaker_closed <= 1'b1;
        cyc(8);
        chk(32'(alarm_latched), 32'h88);
        chk(32'({act_warn, act_soft, act_hard}), 32'h3);
        setp({6{NOM}});
        wr(8'h00, 32'h1);
        cyc(2);
        chk(32'(alarm_latched), 32'h0);
    endtask : t_under
    // Short bursts must not add up; a deep one still waits the full delay
    task t_delay;
        wr(8'h18, 32'h00080003);
        wr(8'h30, 32'h00000300);
        wr(8'h34, 32'h00000300);
        repeat (2) begin
            setp({NOM, NOM, 16'h0400, NOM, NOM, NOM});
            repeat (5) @(posedge aclk);
            setp({6{NOM}});
        end
        cyc(4);
        chk(32'(alarm_latched), 32'h0);
        setp({NOM, NOM, 16'hF000, NOM, NOM, NOM});
        cyc(17);
        chk(32'(alarm_latched), 32'h10);
        cyc(20);
        chk(32'(alarm_latched), 32'h30);
    endtask : t_delay
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    initial begin
        #400000;
        mismatches++;
        end_sim;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        gen_breaker_closed = 1'b1;
        want = {6{NOM}};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_over;
        t_under;
        t_delay;
        end_sim;
    end
endmodule : vpr_relay_test
